//--- tcu_pkg.sv
// Shared constants, types and helpers of the timer capture unit
package tcu_pkg;

  // Register byte offsets
  localparam logic [7:0] TCU_OFS_CONTROL = 8'h00;
  localparam logic [7:0] TCU_OFS_RESULT_LOW = 8'h04;
  localparam logic [7:0] TCU_OFS_RESULT_HIGH = 8'h08;
  localparam logic [7:0] TCU_OFS_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] TCU_OFS_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] TCU_OFS_TIMER_CONTROL = 8'h14;
  localparam logic [7:0] TCU_OFS_TIMER_LOW = 8'h18;
  localparam logic [7:0] TCU_OFS_TIMER_HIGH = 8'h1C;
  localparam logic [7:0] TCU_OFS_ALT_PIN = 8'h20;
  localparam logic [7:0] TCU_OFS_PIN_PORT = 8'h24;

  // Field positions
  localparam int TCU_MODE_LSB = 0;
  localparam int TCU_MODE_MSB = 3;
  localparam int TCU_FLAG_BIT = 2;
  localparam int TCU_TMR_ON_BIT = 0;
  localparam int TCU_TMR_EXT_BIT = 1;
  localparam int TCU_ALT_BIT = 0;
  localparam int TCU_DIR_BIT = 0;
  localparam int TCU_LATCH_BIT = 1;

  // Reset values
  localparam logic [7:0] TCU_RST_CONTROL = 8'h00;
  localparam logic [7:0] TCU_RST_BYTE = 8'h00;
  localparam logic [7:0] TCU_RST_PIN_PORT = 8'h01;

  // Capture mode codes
  localparam logic [3:0] TCU_MODE_FALL = 4'h4;
  localparam logic [3:0] TCU_MODE_RISE = 4'h5;
  localparam logic [3:0] TCU_MODE_RISE4 = 4'h6;
  localparam logic [3:0] TCU_MODE_RISE16 = 4'h7;

  // Prescaler wrap points and instruction clock divider
  localparam logic [3:0] TCU_WRAP4 = 4'h3;
  localparam logic [3:0] TCU_WRAP16 = 4'hF;
  localparam logic [1:0] TCU_INSTR_DIV_LAST = 2'h3;

  localparam logic [1:0] TCU_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } tcu_bus_req_s;

  typedef struct packed {
    logic out;
    logic oeN;
  } tcu_pin_drive_s;

  function automatic logic tcu_is_capture(input logic [3:0] mode);
    tcu_is_capture = (mode[3:2] == 2'b01);
  endfunction

endpackage

//--- tcu_pin_select.sv
// Capture pin routing, pin drive and input synchroniser
`timescale 1ns/1ps
module tcu_pin_select
  import tcu_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic altSelect, // Use alternate pin
  input wire logic dirInput, // Pin direction, 1 = input
  input wire logic portLatch, // Port output latch
  input wire logic pinMainIn, // Main pin level
  input wire logic pinAltIn, // Alternate pin level
  output tcu_pkg::tcu_pin_drive_s pinMainDrv, // Main pin drive
  output tcu_pkg::tcu_pin_drive_s pinAltDrv, // Alternate pin drive
  output logic pinLevel // Synchronised selected level
);
  import tcu_pkg::*;

  logic [1:0] syncFirst;
  logic [1:0] syncSecond;
  tcu_pin_drive_s next_mainDrv;
  tcu_pin_drive_s next_altDrv;

  // Unselected pin is never driven
  assign next_mainDrv = '{out: portLatch, oeN: dirInput | altSelect};
  assign next_altDrv = '{out: portLatch, oeN: dirInput | ~altSelect};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      syncFirst <= 2'h0;
      syncSecond <= 2'h0;
      pinMainDrv <= '{out: 1'b0, oeN: 1'b1};
      pinAltDrv <= '{out: 1'b0, oeN: 1'b1};
      pinLevel <= 1'b0;
    end
    else
    begin
      syncFirst <= {pinAltIn, pinMainIn};
      syncSecond <= syncFirst;
      pinMainDrv <= next_mainDrv;
      pinAltDrv <= next_altDrv;
      // Pad input is read even when driving, so own writes can capture
      pinLevel <= altSelect ? syncSecond[1] : syncSecond[0];
    end
  end
endmodule

//--- tcu_event_qual.sv
// Edge detection and capture prescaler
`timescale 1ns/1ps
module tcu_event_qual
  import tcu_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic pinLevel, // Synchronised pin level
  input wire logic [3:0] mode, // Capture mode select
  output logic captureEvent // One-cycle capture pulse
);
  import tcu_pkg::*;

  logic prevLevel;
  logic [3:0] prescale;
  logic [3:0] next_prescale;
  logic rise;
  logic fall;
  logic active;
  logic next_event;

  assign rise = pinLevel & ~prevLevel;
  assign fall = ~pinLevel & prevLevel;
  assign active = tcu_is_capture(mode);
  // Counter is not cleared between prescaler settings; a switch may fire early
  assign next_prescale = !active ? 4'h0 : (rise ? prescale + 4'h1 : prescale);
  assign next_event = active & (
      (mode == TCU_MODE_FALL && fall) ||
      (mode == TCU_MODE_RISE && rise) ||
      (mode == TCU_MODE_RISE4 && rise && prescale[1:0] == TCU_WRAP4[1:0]) ||
      (mode == TCU_MODE_RISE16 && rise && prescale == TCU_WRAP16));

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      prevLevel <= 1'b0;
      prescale <= 4'h0;
      captureEvent <= 1'b0;
    end
    else
    begin
      prevLevel <= pinLevel;
      prescale <= next_prescale;
      captureEvent <= next_event;
    end
  end
endmodule

//--- tcu_capture_unit.sv
// Timer capture unit top: AHB-Lite registers, companion timer, capture
`timescale 1ns/1ps
module tcu_capture_unit
  import tcu_pkg::*;
(
  input wire logic clock, // System clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic sleep, // Device in sleep
  input wire logic extTimerClk, // External timer clock pin
  input wire logic pinMainIn, // Main capture pin input
  output logic pinMainOut, // Main capture pin output
  output logic pinMainOe_n, // Main capture pin enable, low drives
  input wire logic pinAltIn, // Alternate capture pin input
  output logic pinAltOut, // Alternate capture pin output
  output logic pinAltOe_n, // Alternate capture pin enable, low drives
  output logic irq // Level interrupt
);
  import tcu_pkg::*;

  tcu_bus_req_s busReq;
  tcu_bus_req_s next_busReq;
  logic [7:0] captureControl;
  logic [7:0] resultLow;
  logic [7:0] resultHigh;
  logic [7:0] irqEnable;
  logic [7:0] irqFlags;
  logic [7:0] timerControl;
  logic [15:0] timerCount;
  logic [7:0] altPinSelect;
  logic [7:0] pinPort;
  logic [1:0] instrDiv;
  logic [2:0] extSync;
  logic instrTick;
  logic extTick;
  logic timerTick;
  logic captureEvent;
  logic pinLevel;
  tcu_pin_drive_s mainDrv;
  tcu_pin_drive_s altDrv;
  logic addrPhase;
  logic wrData;
  logic readFlags;
  logic [7:0] wb;
  logic [7:0] readByte;
  logic [31:0] next_hrdata;
  logic [7:0] next_irqFlags;
  logic next_irq;
  logic inPage;
  logic selControl;
  logic selResultLow;
  logic selResultHigh;
  logic selIrqEnable;
  logic selIrqFlags;
  logic selTimerControl;
  logic selTimerLow;
  logic selTimerHigh;
  logic selAltPin;
  logic selPinPort;
  logic wrControl;
  logic wrResultLow;
  logic wrResultHigh;
  logic wrIrqEnable;
  logic wrIrqFlags;
  logic wrTimerControl;
  logic wrTimerLow;
  logic wrTimerHigh;
  logic wrAltPin;
  logic wrPinPort;
  logic [7:0] next_captureControl;
  logic [7:0] next_irqEnable;
  logic [7:0] next_timerControl;
  logic [7:0] next_altPinSelect;
  logic [7:0] next_pinPort;
  logic [15:0] next_timerCount;

  function automatic logic wr_hit(input logic strobe, input logic [7:0] addr,
      input logic [7:0] ofs);
    wr_hit = strobe & (addr == ofs);
  endfunction

  // Bus address phase; above the lowest 256 bytes nothing is mapped
  assign addrPhase = hsel & hready & (htrans == TCU_HTRANS_NONSEQ | htrans == 2'h3);
  assign inPage = (haddr[31:8] == 24'h0);
  // Unmapped writes must not alias onto the register page
  assign next_busReq = '{addr: haddr[7:0], write: hwrite, valid: addrPhase & inPage};
  assign wrData = busReq.valid & busReq.write;
  assign wb = hwdata[7:0];
  assign readFlags = addrPhase & ~hwrite & selIrqFlags;

  // Read select, decoded in the address phase
  assign selControl = inPage & (haddr[7:0] == TCU_OFS_CONTROL);
  assign selResultLow = inPage & (haddr[7:0] == TCU_OFS_RESULT_LOW);
  assign selResultHigh = inPage & (haddr[7:0] == TCU_OFS_RESULT_HIGH);
  assign selIrqEnable = inPage & (haddr[7:0] == TCU_OFS_IRQ_ENABLE);
  assign selIrqFlags = inPage & (haddr[7:0] == TCU_OFS_IRQ_FLAGS);
  assign selTimerControl = inPage & (haddr[7:0] == TCU_OFS_TIMER_CONTROL);
  assign selTimerLow = inPage & (haddr[7:0] == TCU_OFS_TIMER_LOW);
  assign selTimerHigh = inPage & (haddr[7:0] == TCU_OFS_TIMER_HIGH);
  assign selAltPin = inPage & (haddr[7:0] == TCU_OFS_ALT_PIN);
  assign selPinPort = inPage & (haddr[7:0] == TCU_OFS_PIN_PORT);
  assign readByte = selControl ? captureControl :
      selResultLow ? resultLow :
      selResultHigh ? resultHigh :
      selIrqEnable ? irqEnable :
      selIrqFlags ? irqFlags :
      selTimerControl ? timerControl :
      selTimerLow ? timerCount[7:0] :
      selTimerHigh ? timerCount[15:8] :
      selAltPin ? altPinSelect :
      selPinPort ? pinPort : 8'h00;
  assign next_hrdata = (addrPhase & ~hwrite) ? {24'h0, readByte} : 32'h0;

  // Write strobes, decoded in the data phase
  assign wrControl = wr_hit(wrData, busReq.addr, TCU_OFS_CONTROL);
  assign wrResultLow = wr_hit(wrData, busReq.addr, TCU_OFS_RESULT_LOW);
  assign wrResultHigh = wr_hit(wrData, busReq.addr, TCU_OFS_RESULT_HIGH);
  assign wrIrqEnable = wr_hit(wrData, busReq.addr, TCU_OFS_IRQ_ENABLE);
  assign wrIrqFlags = wr_hit(wrData, busReq.addr, TCU_OFS_IRQ_FLAGS);
  assign wrTimerControl = wr_hit(wrData, busReq.addr, TCU_OFS_TIMER_CONTROL);
  assign wrTimerLow = wr_hit(wrData, busReq.addr, TCU_OFS_TIMER_LOW);
  assign wrTimerHigh = wr_hit(wrData, busReq.addr, TCU_OFS_TIMER_HIGH);
  assign wrAltPin = wr_hit(wrData, busReq.addr, TCU_OFS_ALT_PIN);
  assign wrPinPort = wr_hit(wrData, busReq.addr, TCU_OFS_PIN_PORT);

  // Next values of the software registers
  assign next_captureControl = wrControl ? wb : captureControl;
  assign next_irqEnable = wrIrqEnable ? (wb & (8'h01 << TCU_FLAG_BIT)) : irqEnable;
  assign next_timerControl = wrTimerControl ? {6'h00, wb[1:0]} : timerControl;
  assign next_altPinSelect = wrAltPin ? {7'h00, wb[TCU_ALT_BIT]} : altPinSelect;
  assign next_pinPort = wrPinPort ? {6'h00, wb[1:0]} : pinPort;

  // Flag: hardware set wins over read clear and software write
  assign next_irqFlags[TCU_FLAG_BIT] = captureEvent |
      (wrIrqFlags ? wb[TCU_FLAG_BIT] :
      (readFlags ? 1'b0 : irqFlags[TCU_FLAG_BIT]));
  assign next_irqFlags[7:TCU_FLAG_BIT + 1] = '0;
  assign next_irqFlags[TCU_FLAG_BIT - 1:0] = '0;
  assign next_irq = |(next_irqFlags & irqEnable);

  // Timer ticks: instruction clock stops in sleep, external keeps going
  assign instrTick = (instrDiv == TCU_INSTR_DIV_LAST) & ~sleep;
  assign extTick = extSync[1] & ~extSync[2];
  assign timerTick = timerControl[TCU_TMR_ON_BIT] &
      (timerControl[TCU_TMR_EXT_BIT] ? extTick : instrTick);

  // Low byte write beats high byte write and a tick in one cycle
  assign next_timerCount = wrTimerLow ? {timerCount[15:8], wb} :
      wrTimerHigh ? {wb, timerCount[7:0]} :
      timerTick ? timerCount + 16'h0001 : timerCount;

  tcu_pin_select u_pin_select (
    .clock(clock),
    .rst_n(rst_n),
    .altSelect(altPinSelect[TCU_ALT_BIT]),
    .dirInput(pinPort[TCU_DIR_BIT]),
    .portLatch(pinPort[TCU_LATCH_BIT]),
    .pinMainIn(pinMainIn),
    .pinAltIn(pinAltIn),
    .pinMainDrv(mainDrv),
    .pinAltDrv(altDrv),
    .pinLevel(pinLevel)
  );

  tcu_event_qual u_event_qual (
    .clock(clock),
    .rst_n(rst_n),
    .pinLevel(pinLevel),
    .mode(captureControl[TCU_MODE_MSB:TCU_MODE_LSB]),
    .captureEvent(captureEvent)
  );

  assign pinMainOut = mainDrv.out;
  assign pinMainOe_n = mainDrv.oeN;
  assign pinAltOut = altDrv.out;
  assign pinAltOe_n = altDrv.oeN;

  // Bus handshake; zero wait states
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busReq <= '0;
      hreadyout <= 1'b0;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end
    else
    begin
      busReq <= next_busReq;
      hreadyout <= 1'b1;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end

  // Capture flag and interrupt line
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      irqFlags <= TCU_RST_BYTE;
    end
    else
    begin
      irq <= next_irq;
      irqFlags <= next_irqFlags;
    end
  end

  // Software configuration registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      captureControl <= TCU_RST_CONTROL;
      irqEnable <= TCU_RST_BYTE;
      timerControl <= TCU_RST_BYTE;
      altPinSelect <= TCU_RST_BYTE;
      pinPort <= TCU_RST_PIN_PORT;
    end
    else
    begin
      captureControl <= next_captureControl;
      irqEnable <= next_irqEnable;
      timerControl <= next_timerControl;
      altPinSelect <= next_altPinSelect;
      pinPort <= next_pinPort;
    end
  end

  // Capture result; capture wins over a same-cycle software write
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      resultLow <= TCU_RST_BYTE;
      resultHigh <= TCU_RST_BYTE;
    end
    else if (captureEvent)
    begin
      resultLow <= timerCount[7:0];
      resultHigh <= timerCount[15:8];
    end
    else
    begin
      if (wrResultLow)
        resultLow <= wb;
      if (wrResultHigh)
        resultHigh <= wb;
    end
  end

  // Tick sources; the external clock pin passes a synchroniser first
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      instrDiv <= 2'h0;
      extSync <= 3'h0;
    end
    else
    begin
      extSync <= {extSync[1:0], extTimerClk};
      if (!sleep)
        instrDiv <= instrDiv + 2'h1;
    end
  end

  // Companion timer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      timerCount <= 16'h0000;
    else
      timerCount <= next_timerCount;
  end
endmodule

//--- tcu_capture_unit_monitor.sv
// Port checker of the timer capture unit, bound to its top
`timescale 1ns/1ps
module tcu_capture_unit_monitor
(
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hresp, // Response
  input wire logic pinMainIn, // Main pin
  input wire logic pinAltIn, // Alt pin
  input wire logic pinMainOut, // Main drive
  input wire logic pinMainOe_n, // Main enable
  input wire logic pinAltOe_n, // Alt enable
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire acc = hsel && hready && htrans[1];
  wire accW = acc && hwrite;
  logic [3:0] sinceW;
  logic [3:0] sinceC;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sinceW <= 4'hF;
    else if (accW)
      sinceW <= 4'h0;
    else if (sinceW != 4'hF)
      sinceW <= sinceW + 4'h1;
  end
  // Any write or pin change may legally lead to a flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sinceC <= 4'hF;
    else if (accW || pinMainIn != $past(pinMainIn) || pinAltIn != $past(pinAltIn))
      sinceC <= 4'h0;
    else if (sinceC != 4'hF)
      sinceC <= sinceC + 4'h1;
  end
  AST_READY: assert property ($past(rst_n) |-> hreadyout)
    else $error("hreadyout low");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  AST_UPPER: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  AST_RDZERO: assert property (!$past(acc && !hwrite && haddr[31:8] == 24'h0) |-> hrdata == 32'h0)
    else $error("hrdata outside read");
  AST_OEEXCL: assert property (!pinMainOe_n |-> pinAltOe_n)
    else $error("both pins driven");
  AST_IRQFALL: assert property ($fell(irq) |-> ($past(acc) || $past(acc, 2) || $past(acc, 3)))
    else $error("irq fell without access");
  AST_IRQRISE: assert property ($rose(irq) |-> sinceC <= 4'd12)
    else $error("irq rose without cause");
  AST_PINOUT: assert property (!$stable(pinMainOut) |-> sinceW <= 4'd3)
    else $error("pin drive moved alone");
endmodule
bind tcu_capture_unit tcu_capture_unit_monitor mon (.clock, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .pinMainIn, .pinAltIn,
  .pinMainOut, .pinMainOe_n, .pinAltOe_n, .irq);

//--- tcu_pin_model.sv
// Far-side pin model: external sources against the design's drivers
`timescale 1ns/1ps
module tcu_pin_model
(
  input wire logic [1:0] ext, // External levels, bit1 alternate
  input wire logic mainOut, // Main drive
  input wire logic mainOe_n, // Main enable
  input wire logic altOut, // Alt drive
  input wire logic altOe_n, // Alt enable
  output logic mainPin, // Main level
  output logic altPin // Alt level
);
  // External source is weak, a driven pin wins
  assign mainPin = mainOe_n ? ext[0] : mainOut;
  assign altPin = altOe_n ? ext[1] : altOut;
endmodule

//--- tcu_capture_unit_test.sv
// Self-checking bench of the timer capture unit
`timescale 1ns/1ps
module tcu_capture_unit_test;
  import tcu_pkg::*;
  `define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sleep = 1'b0;
  logic extTimerClk = 1'b0;
  logic [1:0] ext = 2'b00;
  logic hreadyout, hresp, irq, pinMainIn, pinAltIn, pinMainOut, pinMainOe_n, pinAltOut, pinAltOe_n;
  logic [31:0] hrdata;
  logic [7:0] rdv;
  int numErrors = 0;
  int nCompared = 0;
  logic [3:0] modes [4] = '{TCU_MODE_FALL, TCU_MODE_RISE, TCU_MODE_RISE4, TCU_MODE_RISE16};
  int cnt [4] = '{1, 1, 4, 16};
  always #25 clock = ~clock;
  tcu_capture_unit dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .sleep, .extTimerClk,
    .pinMainIn, .pinMainOut, .pinMainOe_n, .pinAltIn, .pinAltOut, .pinAltOe_n, .irq);
  tcu_pin_model pins (.ext, .mainOut(pinMainOut), .mainOe_n(pinMainOe_n),
    .altOut(pinAltOut), .altOe_n(pinAltOe_n), .mainPin(pinMainIn), .altPin(pinAltIn));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= TCU_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdv = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rdv, e)
  endtask
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n)
    begin
      @(posedge clock);
      ext <= m;
      repeat (8) @(posedge clock);
      ext <= 2'b00;
      repeat (8) @(posedge clock);
    end
  endtask
  // Off first, then the new mode, then drop any false flag
  task automatic setMode(input logic [3:0] m);
    wr(TCU_OFS_CONTROL, 8'h00);
    wr(TCU_OFS_CONTROL, {4'h0, m});
    repeat (10) @(posedge clock);
    xfer(1'b0, TCU_OFS_IRQ_FLAGS, 8'h00);
  endtask
  task automatic finalReport;
    $display("compared %0d errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    numErrors++;
    finalReport();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(TCU_OFS_PIN_PORT, TCU_RST_PIN_PORT);
    rdc(TCU_OFS_CONTROL, TCU_RST_CONTROL);
    wr(8'h40, 8'h5A);
    rdc(8'h40, 8'h00);
    wr(TCU_OFS_IRQ_ENABLE, 8'hFF);
    rdc(TCU_OFS_IRQ_ENABLE, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      setMode(modes[i]);
      wr(TCU_OFS_TIMER_LOW, 8'h10 + 8'(i));
      wr(TCU_OFS_TIMER_HIGH, 8'hA0 + 8'(i));
      pulse(2'b01, cnt[i] - 1);
      rdc(TCU_OFS_IRQ_FLAGS, 8'h00);
      pulse(2'b01, 1);
      repeat (50) @(posedge clock);
      `CHK(irq, 1'b1)
      rdc(TCU_OFS_RESULT_LOW, 8'h10 + 8'(i));
      rdc(TCU_OFS_RESULT_HIGH, 8'hA0 + 8'(i));
      rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    end
    setMode(TCU_MODE_RISE);
    wr(TCU_OFS_TIMER_LOW, 8'h55);
    pulse(2'b01, 1);
    wr(TCU_OFS_TIMER_LOW, 8'h77);
    pulse(2'b01, 1);
    rdc(TCU_OFS_RESULT_LOW, 8'h77);
    wr(TCU_OFS_IRQ_ENABLE, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(TCU_OFS_IRQ_ENABLE, 8'h04);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1)
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    setMode(TCU_MODE_RISE4);
    pulse(2'b01, 2);
    wr(TCU_OFS_CONTROL, {4'h0, TCU_MODE_RISE16});
    xfer(1'b0, TCU_OFS_IRQ_FLAGS, 8'h00);
    pulse(2'b01, 13);
    rdc(TCU_OFS_IRQ_FLAGS, 8'h00);
    pulse(2'b01, 1);
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    setMode(TCU_MODE_RISE);
    wr(TCU_OFS_PIN_PORT, 8'h00);
    wr(TCU_OFS_PIN_PORT, 8'h02);
    repeat (10) @(posedge clock);
    `CHK({pinMainOe_n, pinMainOut}, 2'b01)
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    wr(TCU_OFS_PIN_PORT, 8'h01);
    wr(TCU_OFS_ALT_PIN, 8'h01);
    pulse(2'b01, 1);
    rdc(TCU_OFS_IRQ_FLAGS, 8'h00);
    pulse(2'b10, 1);
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    wr(TCU_OFS_PIN_PORT, 8'h02);
    repeat (10) @(posedge clock);
    `CHK({pinAltOe_n, pinAltOut, pinMainOe_n}, 3'b011)
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    wr(TCU_OFS_PIN_PORT, 8'h01);
    wr(TCU_OFS_ALT_PIN, 8'h00);
    sleep <= 1'b1;
    wr(TCU_OFS_TIMER_LOW, 8'h20);
    wr(TCU_OFS_TIMER_CONTROL, 8'h01);
    repeat (40) @(posedge clock);
    rdc(TCU_OFS_TIMER_LOW, 8'h20);
    sleep <= 1'b0;
    repeat (40) @(posedge clock);
    xfer(1'b0, TCU_OFS_TIMER_LOW, 8'h00);
    `CHK(rdv > 8'h20, 1'b1)
    sleep <= 1'b1;
    wr(TCU_OFS_TIMER_CONTROL, 8'h03);
    wr(TCU_OFS_TIMER_LOW, 8'h00);
    repeat (5)
    begin
      @(posedge clock);
      extTimerClk <= 1'b1;
      repeat (4) @(posedge clock);
      extTimerClk <= 1'b0;
      repeat (4) @(posedge clock);
    end
    rdc(TCU_OFS_TIMER_LOW, 8'h05);
    pulse(2'b01, 1);
    rdc(TCU_OFS_RESULT_LOW, 8'h05);
    rdc(TCU_OFS_IRQ_FLAGS, 8'h04);
    finalReport();
  end
endmodule
